/* File: him_pkg.sv */
// constants and carrier types of the host interrupt mask block
package him_pkg;

    // ****************************************************
    // register offsets
    // ****************************************************
    localparam int unsigned ADDR_W = 8;
    localparam logic [7:0] OFF_MASK_SET = 8'h88;
    localparam logic [7:0] OFF_MASK_CLR = 8'h8C;
    localparam logic [7:0] OFF_TXEV_SET = 8'h90;
    localparam logic [7:0] OFF_TXEV_CLR = 8'h94;
    localparam logic [7:0] OFF_STAT     = 8'hE0;
    localparam logic [7:0] OFF_STAT_CLR = 8'hE4;
    localparam logic [7:0] OFF_STAT_EN  = 8'hE8;

    // ****************************************************
    // field layout and reset values
    // ****************************************************
    localparam int unsigned GIE_BIT    = 31;
    localparam int unsigned MAKER_BIT  = 30;
    localparam int unsigned RX_SUM_BIT = 7;
    localparam int unsigned TX_SUM_BIT = 6;
    localparam int unsigned TX_CTX_N   = 8;
    // bits software may set or clear in the mask
    localparam logic [31:0] MASK_SW_BITS  = 32'hC7FB_033F;
    // everything but the global enable takes part in the event match
    localparam logic [31:0] MASK_EVT_BITS = 32'h7FFF_FFFF;
    localparam logic [31:0] MASK_RST      = 32'h0000_0000;
    localparam logic [7:0]  TXEV_RST      = 8'h00;

    localparam int unsigned STAT_W      = 2;
    localparam int unsigned ST_TXEV     = 0;
    localparam int unsigned ST_GIE_DROP = 1;
    localparam logic [1:0]  STAT_RST    = 2'h0;

    // ****************************************************
    // carrier types
    // ****************************************************
    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [31:0]       wdata;
    } him_req_s;

    typedef struct packed {
        logic [31:0]         mask;
        logic [TX_CTX_N-1:0] tx_event;
        logic [TX_CTX_N-1:0] ctx_prev;
        logic [STAT_W-1:0]   stat;
        logic [STAT_W-1:0]   stat_en;
        logic [31:0]         rdata;
    } him_state_s;

endpackage

/* File: him_irq_mask.sv */
// interrupt mask and transmit context event registers
`timescale 1ns/1ps

// What this block does
// (R01) reads at mask set or clear offset return the one mask register
// (R02) mask bits below 30 enable the event bit at the same position
// (R03) global enable bit 31 gates the host interrupt; status_irq is not gated by it
// (R04) mask bit 30 enables the maker defined event bit 30
// (R05) mask bits are set/clear, update, or read-only by position
// (R06) mask set at 88h, mask clear at 8Ch
// (R07) a context interrupt comes from a completed last-output command
// (R08) event bit sets on rising context interrupt or written one at set
// (R09) event bit clears only by a one written at the clear offset
// (R10) event bit N belongs to transmit context N, summary event bit 6
// (R11) event bits 31 to 8 read as zero
// (R12) event set at 90h, event clear at 94h
// (R13) read at 94h returns events ANDed with the context enables
// (R14) summary event is the unlatched OR of enabled context events
// (R15) zero bits written at set or clear offsets change nothing
// (R16) host interrupt while global enable and an enabled event are set
module him_irq_mask
    import him_pkg::*;
(
    input  wire logic                sys_clk,
    input  wire logic                rstn,
    input  wire logic                ce,
    input  wire him_req_s            req,
    output logic [31:0]              rdata,
    input  wire logic [31:0]         main_event,
    input  wire logic [TX_CTX_N-1:0] tx_context_irq,
    input  wire logic [TX_CTX_N-1:0] tx_context_enable_in,
    input  wire logic                rx_summary_enable_in,
    input  wire logic                global_irq_drop,
    output logic [TX_CTX_N-1:0]      tx_context_event,
    output logic                     tx_stream_summary_event,
    output logic                     global_irq_enable,
    output logic                     maker_defined_irq_enable,
    output logic                     host_irq,
    output logic                     status_irq
);

    // ****************************************************
    // helpers
    // ****************************************************
    // one-bits of the write act, zero-bits leave the bit alone
    function automatic logic [31:0] w1_apply(
        input logic [31:0] cur,
        input logic [31:0] data,
        input logic        set
    );
        w1_apply = set ? (cur | data) : (cur & ~data); // R15
    endfunction

    function automatic logic hit(
        input him_req_s    r,
        input logic [7:0]  off
    );
        hit = (r.addr == off);
    endfunction

    // ****************************************************
    // state
    // ****************************************************
    him_state_s          st_reg;
    him_state_s          st_next;
    logic [TX_CTX_N-1:0] ctx_rise;
    logic [TX_CTX_N-1:0] txev;
    logic [TX_CTX_N-1:0] txev_and_en;
    logic [31:0]         txev_wide;
    logic [31:0]         txev_w1s;
    logic [31:0]         txev_w1c;
    logic [31:0]         mask;
    logic [31:0]         eff_event;
    logic                gie_drop;

    assign txev        = st_reg.tx_event;
    assign mask        = st_reg.mask;
    assign txev_and_en = txev & tx_context_enable_in;
    // widened copy so the word-wide write helper can act on it
    assign txev_wide   = {{(32-TX_CTX_N){1'b0}}, txev};
    assign txev_w1s    = w1_apply(txev_wide, req.wdata, 1'b1); // R08
    assign txev_w1c    = w1_apply(txev_wide, req.wdata, 1'b0); // R09

    // context interrupt is raised by the DMA side when a
    // last-output command with its interrupt bits completes
    assign ctx_rise = tx_context_irq & ~st_reg.ctx_prev; // R07 R08

    // a software set of bit 31 in the same cycle wins
    assign gie_drop = global_irq_drop && mask[GIE_BIT]
                      && !(req.wr && hit(req, OFF_MASK_SET)
                           && req.wdata[GIE_BIT]);

    // ****************************************************
    // next state
    // ****************************************************
    always_comb begin
        st_next          = st_reg;
        st_next.ctx_prev = tx_context_irq;

        // mask register writes
        if (req.wr && hit(req, OFF_MASK_SET)) begin // R06
            st_next.mask = w1_apply(mask,
                                    req.wdata & MASK_SW_BITS,
                                    1'b1); // R05
        end
        if (req.wr && hit(req, OFF_MASK_CLR)) begin // R06
            st_next.mask = w1_apply(mask,
                                    req.wdata & MASK_SW_BITS,
                                    1'b0); // R05
        end
        // hardware updated bits
        if (gie_drop) begin
            st_next.mask[GIE_BIT] = 1'b0; // R05
        end
        st_next.mask[RX_SUM_BIT] = rx_summary_enable_in; // R05
        st_next.mask[TX_SUM_BIT] = |tx_context_enable_in; // R05

        // transmit context events
        if (req.wr && hit(req, OFF_TXEV_SET)) begin // R12
            st_next.tx_event = txev_w1s[TX_CTX_N-1:0]; // R08
        end
        if (req.wr && hit(req, OFF_TXEV_CLR)) begin // R12
            st_next.tx_event = txev_w1c[TX_CTX_N-1:0]; // R09
        end
        // edge set applied last so it wins over a clear
        st_next.tx_event = st_next.tx_event | ctx_rise; // R08 R10

        // block status, sticky, write one to clear
        if (req.wr && hit(req, OFF_STAT_CLR)) begin
            st_next.stat = st_reg.stat & ~req.wdata[STAT_W-1:0];
        end
        if (req.wr && hit(req, OFF_STAT_EN)) begin
            st_next.stat_en = req.wdata[STAT_W-1:0];
        end
        st_next.stat[ST_TXEV]     = st_next.stat[ST_TXEV] | (|ctx_rise);
        st_next.stat[ST_GIE_DROP] = st_next.stat[ST_GIE_DROP] | gie_drop;

        // read data stand for exactly one cycle
        st_next.rdata = 32'h0000_0000;
        if (req.rd) begin
            case (req.addr)
                OFF_MASK_SET, OFF_MASK_CLR: begin
                    st_next.rdata = mask; // R01
                end
                OFF_TXEV_SET: begin
                    st_next.rdata = {24'h0, txev}; // R11
                end
                OFF_TXEV_CLR: begin
                    st_next.rdata = {24'h0, txev_and_en}; // R13 R11
                end
                OFF_STAT: begin
                    st_next.rdata = {30'h0, st_reg.stat};
                end
                OFF_STAT_EN: begin
                    st_next.rdata = {30'h0, st_reg.stat_en};
                end
                default: begin
                    st_next.rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    // ****************************************************
    // registers
    // ****************************************************
    // reset value of the mask is chosen as all disabled
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            st_reg.mask     <= MASK_RST;
            st_reg.tx_event <= TXEV_RST;
            st_reg.ctx_prev <= TXEV_RST;
            st_reg.stat     <= STAT_RST;
            st_reg.stat_en  <= STAT_RST;
            st_reg.rdata    <= 32'h0000_0000;
        end else if (ce) begin
            st_reg <= st_next;
        end
    end

    // ****************************************************
    // outputs
    // ****************************************************
    // summary is never latched, it follows events and enables
    assign tx_stream_summary_event = |txev_and_en; // R14 R10

    always_comb begin
        eff_event             = main_event;
        eff_event[TX_SUM_BIT] = tx_stream_summary_event; // R10
    end

    // bit 30 and bits below share one match; bit 31 gates all
    assign host_irq = mask[GIE_BIT]
                      && |(eff_event & mask & MASK_EVT_BITS); // R02 R03 R04 R16

    assign status_irq               = |(st_reg.stat & st_reg.stat_en);
    assign rdata                    = st_reg.rdata;
    assign tx_context_event         = txev;
    assign global_irq_enable        = mask[GIE_BIT];
    assign maker_defined_irq_enable = mask[MAKER_BIT];

    // ****************************************************
    // checks
    // ****************************************************
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);

    sequence s_mask_rd;
        ce && req.rd && (hit(req, OFF_MASK_SET) || hit(req, OFF_MASK_CLR));
    endsequence

    sequence s_txclr_rd;
        ce && req.rd && hit(req, OFF_TXEV_CLR);
    endsequence

    sequence s_ctx2_rise;
        ce && tx_context_irq[2] && !st_reg.ctx_prev[2]
        && tx_context_enable_in[2];
    endsequence

    // hardware drop of the global enable with no software set beside it
    sequence s_gie_drop;
        ce && global_irq_drop
        && !(req.wr && hit(req, OFF_MASK_SET) && req.wdata[GIE_BIT]);
    endsequence

    sequence s_no_read;
        ce && !req.rd;
    endsequence

    a_mask_read_back: assert property ( // R01
        s_mask_rd |=> rdata == $past(mask))
        else $error("mask read returned wrong value");

    a_gie_gates_irq: assert property ( // R03
        !mask[GIE_BIT] |-> !host_irq)
        else $error("host irq raised with global enable clear");

    a_enabled_evt_irq: assert property ( // R02
        mask[GIE_BIT] && mask[1] && main_event[1] |-> host_irq)
        else $error("enabled event did not raise host irq");

    a_maker_evt_irq: assert property ( // R04
        mask[GIE_BIT] && mask[MAKER_BIT] && main_event[MAKER_BIT]
        |-> host_irq)
        else $error("maker event did not raise host irq");

    a_ctx_edge_sum: assert property ( // R08
        s_ctx2_rise ##1 tx_context_enable_in[2]
        |-> txev[2] && tx_stream_summary_event)
        else $error("context edge did not reach summary event");

    a_event_sticky: assert property ( // R09
        ce && !(req.wr && hit(req, OFF_TXEV_CLR))
        |=> (txev & $past(txev)) == $past(txev))
        else $error("event bit lost without a clear write");

    a_clear_w1: assert property ( // R09
        ce && req.wr && hit(req, OFF_TXEV_CLR) && req.wdata[0]
        && !ctx_rise[0] |=> !txev[0])
        else $error("write one to clear left event set");

    a_set_w1: assert property ( // R08
        ce && req.wr && hit(req, OFF_TXEV_SET) && req.wdata[1]
        |=> txev[1])
        else $error("write one to set did not set event");

    a_txclr_read: assert property ( // R13
        s_txclr_rd |=> rdata == {24'h0, $past(txev_and_en)})
        else $error("clear offset read not masked by enables");

    a_rsvd_zero: assert property ( // R11
        ce && req.rd && hit(req, OFF_TXEV_SET) |=> rdata[31:8] == 24'h0)
        else $error("reserved event bits read non-zero");

    a_mask_ro_bits: assert property ( // R05
        ce && req.wr && hit(req, OFF_MASK_SET) |=> mask[29:27] == 3'h0)
        else $error("read-only mask bits became set");

    a_zero_keeps: assert property ( // R15
        ce && req.wr && hit(req, OFF_MASK_CLR) && !req.wdata[MAKER_BIT]
        |=> mask[MAKER_BIT] == $past(mask[MAKER_BIT]))
        else $error("zero write changed a mask bit");

    // read data stand one cycle only, so idle cycles give zero
    a_rd_idle_zero: assert property ( // R01
        s_no_read |=> rdata == 32'h0000_0000)
        else $error("read data stood without a read");

    a_gie_hw_drop: assert property ( // R05
        s_gie_drop |=> !global_irq_enable)
        else $error("hardware drop left global enable set");

    a_tx_sum_enable: assert property ( // R05
        ce |=> mask[TX_SUM_BIT] == $past(|tx_context_enable_in))
        else $error("transmit summary enable not updated");

    a_rx_sum_enable: assert property ( // R05
        ce |=> mask[RX_SUM_BIT] == $past(rx_summary_enable_in))
        else $error("receive summary enable not updated");

endmodule

/* File: him_ctx_src.sv */
// transmit context interrupt source model for the mask block bench
`timescale 1ns/1ps
module him_ctx_src (
    input  wire logic       sys_clk,
    input  wire logic       rstn,
    input  wire logic [7:0] last_done,
    input  wire logic [7:0] irq_bits,
    output logic      [7:0] tx_context_irq
);
    // level holds while the completion stands, so one edge per completion
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            tx_context_irq <= 8'h00;
        end else begin
            tx_context_irq <= last_done & irq_bits;
        end
    end
endmodule

/* File: tb.sv */
// self-checking bench of the interrupt mask block
`timescale 1ns/1ps
module tb
    import him_pkg::*;
;
    typedef struct packed {
        logic        w;
        logic [7:0]  a;
        logic [31:0] d;
    } him_row_s;

    logic        sys_clk = 1'b0;
    logic        rstn = 1'b0;
    logic        ce = 1'b1;
    him_req_s    req = '0;
    logic [31:0] rdata;
    logic [31:0] main_event = 32'h0;
    logic [7:0]  last_done = 8'h00;
    logic [7:0]  irq_bits = 8'h00;
    logic [7:0]  tx_context_irq;
    logic [7:0]  tx_context_enable_in = 8'h00;
    logic        rx_summary_enable_in = 1'b0;
    logic        global_irq_drop = 1'b0;
    logic [7:0]  tx_context_event;
    logic        tx_stream_summary_event;
    logic        global_irq_enable;
    logic        maker_defined_irq_enable;
    logic        host_irq;
    logic        status_irq;
    int          mismatches = 0;
    int          checks = 0;
    // reads carry the expected value in d
    him_row_s    rows [15] = '{
        '{1'b0, 8'h88, 32'h0}, '{1'b0, 8'h00, 32'h0},
        '{1'b1, 8'h88, 32'hFFFFFFFF}, '{1'b0, 8'h8C, 32'hC7FB033F},
        '{1'b1, 8'h8C, 32'h00000001}, '{1'b0, 8'h88, 32'hC7FB033E},
        '{1'b1, 8'h90, 32'hFFFFFFFF}, '{1'b0, 8'h90, 32'h000000FF},
        '{1'b0, 8'h94, 32'h00000000}, '{1'b1, 8'h94, 32'h0000000F},
        '{1'b0, 8'h90, 32'h000000F0}, '{1'b1, 8'h90, 32'h00000000},
        '{1'b0, 8'h90, 32'h000000F0}, '{1'b1, 8'h94, 32'h000000FF},
        '{1'b0, 8'h90, 32'h00000000}};

    him_ctx_src src (.sys_clk(sys_clk), .rstn(rstn), .last_done(last_done),
        .irq_bits(irq_bits), .tx_context_irq(tx_context_irq));

    him_irq_mask dut (.sys_clk(sys_clk), .rstn(rstn), .ce(ce), .req(req),
        .rdata(rdata), .main_event(main_event),
        .tx_context_irq(tx_context_irq),
        .tx_context_enable_in(tx_context_enable_in),
        .rx_summary_enable_in(rx_summary_enable_in),
        .global_irq_drop(global_irq_drop),
        .tx_context_event(tx_context_event),
        .tx_stream_summary_event(tx_stream_summary_event),
        .global_irq_enable(global_irq_enable),
        .maker_defined_irq_enable(maker_defined_irq_enable),
        .host_irq(host_irq), .status_irq(status_irq));

    // ****************************************************
    // bus and compare tasks
    // ****************************************************
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        req <= him_req_s'{1'b1, 1'b0, a, d};
        @(posedge sys_clk);
        req <= '0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge sys_clk);
        req <= him_req_s'{1'b0, 1'b1, a, 32'h0};
        @(posedge sys_clk);
        req <= '0;
        #1;
        chk(rdata, e);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic summarize();
        if (mismatches == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ****************************************************
    // clock, watchdog, sequence
    // ****************************************************
    initial begin
        forever #50 sys_clk = ~sys_clk;
    end

    // about 80 cycles expected, 25 times that is a hang
    initial begin
        #200000;
        mismatches++;
        summarize();
    end

    initial begin
        repeat (12) @(posedge sys_clk);
        rstn <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i].w) begin
                wr(rows[i].a, rows[i].d);
            end else begin
                rd(rows[i].a, rows[i].d);
            end
        end
        main_event <= 32'h00000001;
        tick(1);
        chk(host_irq, 1'b0);
        main_event <= 32'h00000002;
        tick(1);
        chk(host_irq, 1'b1);
        wr(8'h8C, 32'h80000000);
        chk(host_irq, 1'b0);
        main_event <= 32'h40000000;
        wr(8'h88, 32'h80000000);
        chk(host_irq, 1'b1);
        main_event <= 32'h0;
        wr(8'hE8, 32'h00000003);
        wr(8'hE4, 32'h00000003);
        tx_context_enable_in <= 8'h04;
        irq_bits <= 8'h04;
        last_done <= 8'h04;
        tick(3);
        chk(tx_context_event, 8'h04);
        chk(tx_stream_summary_event, 1'b1);
        chk({host_irq, status_irq}, 2'h3);
        rd(8'h94, 32'h00000004);
        rd(8'h90, 32'h00000004);
        rd(8'hE0, 32'h00000001);
        wr(8'hE4, 32'h00000001);
        chk(status_irq, 1'b0);
        wr(8'h94, 32'h00000004);
        tick(2);
        chk(tx_context_event, 8'h00);
        chk(tx_stream_summary_event, 1'b0);
        rx_summary_enable_in <= 1'b1;
        global_irq_drop <= 1'b1;
        tick(1);
        global_irq_drop <= 1'b0;
        chk(global_irq_enable, 1'b0);
        rd(8'h88, 32'h47FB03FE);
        rd(8'hE0, 32'h00000002);
        tx_context_enable_in <= 8'h00;
        rx_summary_enable_in <= 1'b0;
        last_done <= 8'h00;
        tick(2);
        rstn <= 1'b0;
        tick(1);
        chk({host_irq, global_irq_enable, tx_context_event}, 10'h0);
        rstn <= 1'b1;
        rd(8'h88, 32'h0);
        summarize();
    end
endmodule
